// File: rtl/lpqm_lpf.sv
`default_nettype none
module lpqm_lpf import lpqm_pkg::*; #(
    parameter int W = 24,
    parameter int SHIFT = 6
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic clr_i,
    input wire logic valid_i,
    input wire logic [W-1:0] x_i,
    output logic [W-1:0] y_o
);
    // unity dc gain, single pole at fs/(2*pi*2^SHIFT); guard bits keep the fraction
    logic signed [W+SHIFT-1:0] acc_q;
    logic signed [W+SHIFT-1:0] x_ext;

    assign x_ext = {{SHIFT{x_i[W-1]}}, x_i};
    assign y_o = acc_q[W+SHIFT-1:SHIFT];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_q <= '0;
        end else if (ce_i) begin
            if (clr_i) begin
                acc_q <= '0;
            end else if (valid_i) begin
                acc_q <= acc_q + x_ext - (acc_q >>> SHIFT);
            end
        end
    end
endmodule // lpqm_lpf
`default_nettype wire

// File: rtl/lpqm_params.svh
`ifndef LPQM_PARAMS_SVH
`define LPQM_PARAMS_SVH

`define LPQM_IDX_LINE_PERIOD_OR_FREQUENCY 8'h0A
`define LPQM_IDX_FIRST_MODE_CONTROL 8'h0B
`define LPQM_IDX_SECOND_MODE_CONTROL 8'h0C
`define LPQM_IDX_CROSSING_TIMEOUT_RELOAD 8'h11
`define LPQM_IDX_SAG_THRESHOLD 8'h14
`define LPQM_IDX_SAG_CYCLE_COUNT 8'h15
`define LPQM_IDX_VOLTAGE_PEAK_THRESHOLD 8'h16
`define LPQM_IDX_CURRENT_PEAK_THRESHOLD 8'h17
`define LPQM_IDX_CURRENT_PEAK_RECORD 8'h18
`define LPQM_IDX_VOLTAGE_PEAK_RECORD 8'h19
`define LPQM_IDX_VOLTAGE_PEAK_RECORD_RC 8'h1A
`define LPQM_IDX_CURRENT_PEAK_RECORD_RC 8'h1B
`define LPQM_IDX_MIRQEN 8'hDB
`define LPQM_IDX_MIRQST 8'hDE
`define LPQM_IDX_PSMEN 8'hEC
`define LPQM_IDX_PSMFL 8'hF8

`define LPQM_FIRST_MODE_CONTROL_INTEG_BIT 0
`define LPQM_SECOND_MODE_CONTROL_FREQUENCY_SELECT_BIT 0
`define LPQM_SECOND_MODE_CONTROL_LPF_BYP_BIT 1
`define LPQM_MIRQ_ZX_BIT 0
`define LPQM_MIRQ_CROSSING_TIMEOUT_FLAG_BIT 1
`define LPQM_MIRQ_PKV_BIT 2
`define LPQM_MIRQ_PKI_BIT 3
`define LPQM_MIRQ_MASK 8'h0F
`define LPQM_PSM_SAG_BIT 0
`define LPQM_PSM_MASK 8'h01

`define LPQM_CROSSING_TIMEOUT_RELOAD_RST 12'hFFF
`define LPQM_SAG_OFF_MAX 16'h0001
`define LPQM_SAG_CYCLE_COUNT_MIN 8'h02

`define LPQM_CLK_PS 10000
`define LPQM_TO_TICK_PS 39062500
`define LPQM_PER_TICK_PS 2441406
`define LPQM_TO_TICK_CYC (`LPQM_TO_TICK_PS / `LPQM_CLK_PS)
`define LPQM_PER_TICK_CYC (`LPQM_PER_TICK_PS / `LPQM_CLK_PS)
`define LPQM_FREQ_NUM 23'h640000
`define LPQM_DIV_STEPS 5'h17
`define LPQM_LPF_SHIFT 6
`define LPQM_INT_SHIFT 10

`endif

// File: rtl/lpqm_pkg.sv
`default_nettype none
package lpqm_pkg;
    typedef struct packed {
        logic valid;
        logic [23:0] v;
        logic [23:0] i;
    } lpqm_sample_t;

    typedef enum {DIV_IDLE, DIV_RUN} lpqm_div_state_t;

    function automatic logic [23:0] lpqm_abs24(input logic [23:0] x);
        return x[23] ? (~x + 24'h000001) : x;
    endfunction
endpackage
`default_nettype wire

// File: rtl/lpqm_top.sv
// Design decision made here: the APB interface to the registers.
`include "lpqm_params.svh"
`default_nettype none
module lpqm_top import lpqm_pkg::*; #(
    parameter int TO_TICK_CYC = `LPQM_TO_TICK_CYC,
    parameter int PER_TICK_CYC = `LPQM_PER_TICK_CYC,
    parameter int PADDR_W = 10
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [PADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire lpqm_sample_t samples_i,
    output logic [23:0] i_proc_o,
    output logic i_proc_valid_o,
    output logic zx_o,
    output logic cal_zx_o,
    output logic meter_irq_o,
    output logic psm_irq_o
);
    localparam int TW = $clog2(TO_TICK_CYC + 1);
    localparam int PW = $clog2(PER_TICK_CYC + 1);

    function automatic logic hit(input logic [PADDR_W-1:0] a, input logic [7:0] idx);
        return a == PADDR_W'({idx, 2'b00});
    endfunction

    logic rst_s1_q, rst_n;
    logic [7:0] first_mode_control_q, second_mode_control_q, sag_cyc_q, men_q, mst_q, psme_q, psmf_q;
    logic [11:0] crossing_timeout_reload_q, to_cnt_q;
    logic [15:0] sag_thr_q, vpk_thr_q, ipk_thr_q, line_period_or_frequency_q, per_cnt_q;
    logic [23:0] voltage_peak_record_q, current_peak_record_q, i_int, v_lpf, v_sel, i_cur, abs_v, abs_i, abs_s;
    logic [TW-1:0] to_pre_q;
    logic [PW-1:0] per_pre_q;
    logic vpos_q, cyc_below_q;
    logic [7:0] sag_cnt_q;
    logic [31:0] rdata;
    logic mapped, acc, wr, rd;
    logic integ_en, frequency_select, byp, zx_pulse, to_tick, to_expire, sag_en, below, sag_set;
    logic pkv_set, pki_set, rc_v, rc_i;
    lpqm_div_state_t div_st_q;
    logic [22:0] quo_q;
    logic [15:0] den_q, quo_sat;
    logic [16:0] rem_q, rem_sh;
    logic [4:0] div_cnt_q;
    logic div_done;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // register bus: one wait state so read data and pready both leave flip-flops
    assign acc = psel_i & penable_i & pready_o;
    assign wr = acc & pwrite_i;
    assign rd = acc & ~pwrite_i;
    assign rc_v = rd & hit(paddr_i, `LPQM_IDX_VOLTAGE_PEAK_RECORD_RC);
    assign rc_i = rd & hit(paddr_i, `LPQM_IDX_CURRENT_PEAK_RECORD_RC);

    always_comb begin
        rdata = 32'h00000000;
        mapped = 1'b1;
        if (hit(paddr_i, `LPQM_IDX_LINE_PERIOD_OR_FREQUENCY)) rdata[15:0] = line_period_or_frequency_q;
        else if (hit(paddr_i, `LPQM_IDX_FIRST_MODE_CONTROL)) rdata[7:0] = first_mode_control_q;
        else if (hit(paddr_i, `LPQM_IDX_SECOND_MODE_CONTROL)) rdata[7:0] = second_mode_control_q;
        else if (hit(paddr_i, `LPQM_IDX_CROSSING_TIMEOUT_RELOAD)) rdata[11:0] = crossing_timeout_reload_q;
        else if (hit(paddr_i, `LPQM_IDX_SAG_THRESHOLD)) rdata[15:0] = sag_thr_q;
        else if (hit(paddr_i, `LPQM_IDX_SAG_CYCLE_COUNT)) rdata[7:0] = sag_cyc_q;
        else if (hit(paddr_i, `LPQM_IDX_VOLTAGE_PEAK_THRESHOLD)) rdata[15:0] = vpk_thr_q;
        else if (hit(paddr_i, `LPQM_IDX_CURRENT_PEAK_THRESHOLD)) rdata[15:0] = ipk_thr_q;
        else if (hit(paddr_i, `LPQM_IDX_CURRENT_PEAK_RECORD)) rdata[23:0] = current_peak_record_q;
        else if (hit(paddr_i, `LPQM_IDX_VOLTAGE_PEAK_RECORD)) rdata[23:0] = voltage_peak_record_q;
        else if (hit(paddr_i, `LPQM_IDX_VOLTAGE_PEAK_RECORD_RC)) rdata[23:0] = voltage_peak_record_q;
        else if (hit(paddr_i, `LPQM_IDX_CURRENT_PEAK_RECORD_RC)) rdata[23:0] = current_peak_record_q;
        else if (hit(paddr_i, `LPQM_IDX_MIRQEN)) rdata[7:0] = men_q;
        else if (hit(paddr_i, `LPQM_IDX_MIRQST)) rdata[7:0] = mst_q;
        else if (hit(paddr_i, `LPQM_IDX_PSMEN)) rdata[7:0] = psme_q;
        else if (hit(paddr_i, `LPQM_IDX_PSMFL)) rdata[7:0] = psmf_q;
        else mapped = 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end else if (ce_i) begin
            pready_o <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
            prdata_o <= (psel_i & penable_i & ~pready_o & ~pwrite_i) ? rdata : 32'h00000000;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            first_mode_control_q <= 8'h00;
            second_mode_control_q <= 8'h00;
            crossing_timeout_reload_q <= `LPQM_CROSSING_TIMEOUT_RELOAD_RST;
            sag_thr_q <= 16'h0000;
            sag_cyc_q <= 8'h00;
            vpk_thr_q <= 16'h0000;
            ipk_thr_q <= 16'h0000;
            men_q <= 8'h00;
            psme_q <= 8'h00;
        end else if (ce_i && wr) begin
            if (hit(paddr_i, `LPQM_IDX_FIRST_MODE_CONTROL)) first_mode_control_q <= pwdata_i[7:0];
            if (hit(paddr_i, `LPQM_IDX_SECOND_MODE_CONTROL)) second_mode_control_q <= pwdata_i[7:0];
            if (hit(paddr_i, `LPQM_IDX_CROSSING_TIMEOUT_RELOAD)) crossing_timeout_reload_q <= pwdata_i[11:0];
            if (hit(paddr_i, `LPQM_IDX_SAG_THRESHOLD)) sag_thr_q <= pwdata_i[15:0];
            if (hit(paddr_i, `LPQM_IDX_SAG_CYCLE_COUNT)) sag_cyc_q <= pwdata_i[7:0];
            if (hit(paddr_i, `LPQM_IDX_VOLTAGE_PEAK_THRESHOLD)) vpk_thr_q <= pwdata_i[15:0];
            if (hit(paddr_i, `LPQM_IDX_CURRENT_PEAK_THRESHOLD)) ipk_thr_q <= pwdata_i[15:0];
            if (hit(paddr_i, `LPQM_IDX_MIRQEN)) men_q <= pwdata_i[7:0] & `LPQM_MIRQ_MASK;
            if (hit(paddr_i, `LPQM_IDX_PSMEN)) psme_q <= pwdata_i[7:0] & `LPQM_PSM_MASK;
        end
    end

    assign integ_en = first_mode_control_q[`LPQM_FIRST_MODE_CONTROL_INTEG_BIT];
    assign frequency_select = second_mode_control_q[`LPQM_SECOND_MODE_CONTROL_FREQUENCY_SELECT_BIT];
    assign byp = second_mode_control_q[`LPQM_SECOND_MODE_CONTROL_LPF_BYP_BIT];

    // integrator held cleared while off so enabling it starts from rest
    lpqm_lpf #(.W(24), .SHIFT(`LPQM_INT_SHIFT)) u_integ (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .clr_i(~integ_en),
        .valid_i(samples_i.valid),
        .x_i(samples_i.i),
        .y_o(i_int)
    );

    lpqm_lpf #(.W(24), .SHIFT(`LPQM_LPF_SHIFT)) u_vlpf (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .clr_i(1'b0),
        .valid_i(samples_i.valid),
        .x_i(samples_i.v),
        .y_o(v_lpf)
    );

    assign i_cur = integ_en ? i_int : samples_i.i;
    assign v_sel = byp ? samples_i.v : v_lpf;
    assign abs_v = lpqm_abs24(samples_i.v);
    assign abs_i = lpqm_abs24(i_cur);
    assign abs_s = lpqm_abs24(v_sel);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            i_proc_o <= 24'h000000;
            i_proc_valid_o <= 1'b0;
        end else if (ce_i) begin
            i_proc_valid_o <= samples_i.valid;
            if (samples_i.valid) i_proc_o <= i_cur;
        end
    end

    // one crossing per line period: negative to non-negative only
    assign zx_pulse = samples_i.valid & ~v_sel[23] & ~vpos_q;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            vpos_q <= 1'b1;
            zx_o <= 1'b1;
            cal_zx_o <= 1'b0;
        end else if (ce_i) begin
            if (samples_i.valid) vpos_q <= ~v_sel[23];
            zx_o <= samples_i.valid ? ~v_sel[23] : vpos_q;
            cal_zx_o <= zx_pulse;
        end
    end

    assign to_tick = to_pre_q == TW'(TO_TICK_CYC - 1);
    assign to_expire = to_tick & ~zx_pulse & (to_cnt_q == 12'h001);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            to_pre_q <= '0;
            to_cnt_q <= `LPQM_CROSSING_TIMEOUT_RELOAD_RST;
        end else if (ce_i) begin
            if (zx_pulse) begin
                to_pre_q <= '0;
                to_cnt_q <= crossing_timeout_reload_q;
            end else if (to_tick) begin
                to_pre_q <= '0;
                if (to_cnt_q != 12'h000) to_cnt_q <= to_cnt_q - 12'h001;
            end else begin
                to_pre_q <= to_pre_q + TW'(1);
            end
        end
    end

    // period counter saturates so very slow lines read as full scale
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            per_pre_q <= '0;
            per_cnt_q <= 16'h0000;
        end else if (ce_i) begin
            if (zx_pulse) begin
                per_pre_q <= '0;
                per_cnt_q <= 16'h0000;
            end else if (per_pre_q == PW'(PER_TICK_CYC - 1)) begin
                per_pre_q <= '0;
                if (per_cnt_q != 16'hFFFF) per_cnt_q <= per_cnt_q + 16'h0001;
            end else begin
                per_pre_q <= per_pre_q + PW'(1);
            end
        end
    end

    // frequency = num / period, restoring division over 23 cycles
    assign rem_sh = {rem_q[15:0], quo_q[22]};
    assign div_done = (div_st_q == DIV_RUN) & (div_cnt_q == 5'h01);
    assign quo_sat = (quo_q[21:15] != 7'h00) ? 16'hFFFF : {quo_q[14:0], (rem_sh >= {1'b0, den_q})};

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            div_st_q <= DIV_IDLE;
            quo_q <= 23'h000000;
            rem_q <= 17'h00000;
            den_q <= 16'h0000;
            div_cnt_q <= 5'h00;
        end else if (ce_i) begin
            unique case (div_st_q)
                DIV_IDLE: begin
                    if (zx_pulse && frequency_select) begin
                        div_st_q <= DIV_RUN;
                        quo_q <= `LPQM_FREQ_NUM;
                        rem_q <= 17'h00000;
                        den_q <= per_cnt_q;
                        div_cnt_q <= `LPQM_DIV_STEPS;
                    end
                end
                DIV_RUN: begin
                    if (rem_sh >= {1'b0, den_q}) begin
                        rem_q <= rem_sh - {1'b0, den_q};
                        quo_q <= {quo_q[21:0], 1'b1};
                    end else begin
                        rem_q <= rem_sh;
                        quo_q <= {quo_q[21:0], 1'b0};
                    end
                    div_cnt_q <= div_cnt_q - 5'h01;
                    if (div_done) div_st_q <= DIV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            line_period_or_frequency_q <= 16'h0000;
        end else if (ce_i) begin
            if (div_done) line_period_or_frequency_q <= quo_sat;
            else if (zx_pulse && !frequency_select) line_period_or_frequency_q <= per_cnt_q;
        end
    end

    assign sag_en = (sag_thr_q > `LPQM_SAG_OFF_MAX) & (sag_cyc_q >= `LPQM_SAG_CYCLE_COUNT_MIN);
    assign below = sag_en & (abs_s[23:16] == 8'h00) & (sag_thr_q > abs_s[15:0]);
    assign sag_set = zx_pulse & cyc_below_q & below & ((sag_cnt_q + 8'h01) == (sag_cyc_q - 8'h01));

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cyc_below_q <= 1'b0;
            sag_cnt_q <= 8'h00;
        end else if (ce_i && samples_i.valid) begin
            if (zx_pulse) begin
                cyc_below_q <= below;
                if (cyc_below_q && below) begin
                    if (sag_cnt_q != 8'hFF) sag_cnt_q <= sag_cnt_q + 8'h01;
                end else begin
                    sag_cnt_q <= 8'h00;
                end
            end else if (!below) begin
                cyc_below_q <= 1'b0;
            end
        end
    end

    assign pkv_set = samples_i.valid & (abs_v[23:8] > vpk_thr_q);
    assign pki_set = samples_i.valid & (abs_i[23:8] > ipk_thr_q);

    // a sample that lands on the clearing read is kept, not lost
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            voltage_peak_record_q <= 24'h000000;
            current_peak_record_q <= 24'h000000;
        end else if (ce_i) begin
            if (rc_v) voltage_peak_record_q <= samples_i.valid ? abs_v : 24'h000000;
            else if (samples_i.valid && abs_v > voltage_peak_record_q) voltage_peak_record_q <= abs_v;
            if (rc_i) current_peak_record_q <= samples_i.valid ? abs_i : 24'h000000;
            else if (samples_i.valid && abs_i > current_peak_record_q) current_peak_record_q <= abs_i;
        end
    end

    // flags clear by writing one; a set in the same cycle wins
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mst_q <= 8'h00;
            psmf_q <= 8'h00;
            meter_irq_o <= 1'b0;
            psm_irq_o <= 1'b0;
        end else if (ce_i) begin
            mst_q <= (mst_q & ~((wr && hit(paddr_i, `LPQM_IDX_MIRQST)) ? pwdata_i[7:0] : 8'h00))
                | (8'(zx_pulse) << `LPQM_MIRQ_ZX_BIT)
                | (8'(to_expire) << `LPQM_MIRQ_CROSSING_TIMEOUT_FLAG_BIT)
                | (8'(pkv_set) << `LPQM_MIRQ_PKV_BIT)
                | (8'(pki_set) << `LPQM_MIRQ_PKI_BIT);
            psmf_q <= (psmf_q & ~((wr && hit(paddr_i, `LPQM_IDX_PSMFL)) ? pwdata_i[7:0] : 8'h00))
                | (8'(sag_set) << `LPQM_PSM_SAG_BIT);
            meter_irq_o <= |(mst_q & men_q);
            psm_irq_o <= |(psmf_q & psme_q);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    property p_integ_off;
        ce_i && samples_i.valid && !integ_en |=> i_proc_o == $past(samples_i.i);
    endproperty
    a_integ_off: assert property (p_integ_off) else $error("integrator active while off");

    property p_zx_flag;
        ce_i && zx_pulse |=> mst_q[`LPQM_MIRQ_ZX_BIT] && cal_zx_o;
    endproperty
    a_zx_flag: assert property (p_zx_flag) else $error("crossing not flagged");

    property p_to_reload;
        ce_i && zx_pulse |=> to_cnt_q == $past(crossing_timeout_reload_q) && to_pre_q == '0;
    endproperty
    a_to_reload: assert property (p_to_reload) else $error("timeout not reloaded");

    property p_to_flag;
        ce_i && to_expire |=> mst_q[`LPQM_MIRQ_CROSSING_TIMEOUT_FLAG_BIT] && to_cnt_q == 12'h000;
    endproperty
    a_to_flag: assert property (p_to_flag) else $error("timeout flag missing");

    property p_period;
        ce_i && zx_pulse && !frequency_select && div_st_q == DIV_IDLE |=> line_period_or_frequency_q == $past(per_cnt_q);
    endproperty
    a_period: assert property (p_period) else $error("period not stored");

    property p_div_len;
        ce_i && div_st_q == DIV_IDLE && zx_pulse && frequency_select |=> div_st_q == DIV_RUN ##[22:400] div_done;
    endproperty
    a_div_len: assert property (p_div_len) else $error("frequency divide overran");

    property p_sag_off;
        ce_i && sag_thr_q <= `LPQM_SAG_OFF_MAX && !psmf_q[`LPQM_PSM_SAG_BIT]
            |=> !psmf_q[`LPQM_PSM_SAG_BIT];
    endproperty
    a_sag_off: assert property (p_sag_off) else $error("sag detected while disabled");

    property p_sag_irq;
        ce_i && sag_set && psme_q[`LPQM_PSM_SAG_BIT] && ce_i ##1 ce_i |=> psm_irq_o;
    endproperty
    a_sag_irq: assert property (p_sag_irq) else $error("sag interrupt missing");

    property p_pkv;
        ce_i && pkv_set |=> mst_q[`LPQM_MIRQ_PKV_BIT];
    endproperty
    a_pkv: assert property (p_pkv) else $error("voltage peak not flagged");

    property p_peak_hold;
        ce_i && !rc_v |=> voltage_peak_record_q >= $past(voltage_peak_record_q);
    endproperty
    a_peak_hold: assert property (p_peak_hold) else $error("voltage record fell");

    property p_rc;
        ce_i && rc_v && !samples_i.valid |=> voltage_peak_record_q == 24'h000000;
    endproperty
    a_rc: assert property (p_rc) else $error("read-clear left record");

    c_zx: cover property (ce_i && zx_pulse);
    c_timeout: cover property (ce_i && to_expire);
    c_sag: cover property (ce_i && sag_set);
    c_freq: cover property (ce_i && div_done);
endmodule // lpqm_top
`default_nettype wire

// File: tb/line_power_quality_monitor_bench.sv
`include "lpqm_params.svh"
`default_nettype none
module line_power_quality_monitor_bench import lpqm_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, run = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, rd, perr;
    logic [23:0] amp = 24'h100000, cap, i_proc;
    logic [15:0] half = 16'h0080;
    logic pready, pslverr, i_proc_v, zx, cal_zx, mirq, pirq, ok;
    lpqm_sample_t samples;
    int n_mismatch = 0, n_checks = 0, cyc = 0, t0;
    logic [31:0] prdata_w;
    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    lpqm_wave_src src_u (.clk_i(clk), .run_i(run), .half_i(half), .amp_i(amp),
        .samples_o(samples));
    lpqm_top #(.TO_TICK_CYC(4), .PER_TICK_CYC(2)) dut_u (.clk_i(clk), .rst_n_i(rst_n),
        .ce_i(1'b1), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata_w), .pready_o(pready), .pslverr_o(pslverr),
        .samples_i(samples), .i_proc_o(i_proc), .i_proc_valid_o(i_proc_v), .zx_o(zx),
        .cal_zx_o(cal_zx), .meter_irq_o(mirq), .psm_irq_o(pirq));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_rng(input string what, input logic [31:0] lo, hi, got);
        n_checks++;
        if ((^got === 1'bx) || got < lo || got > hi) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h..%h seen %h", what, lo, hi, got);
        end
    endtask
    task automatic hang(input string what);
        n_mismatch++;
        $display("[FAIL] %s expected event seen none", what);
        wrap_up();
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge clk);
        if (k == 20) hang("apb ready");
        rd = prdata_w;
        perr = {31'h0, pslverr};
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic poll(input logic [7:0] idx, input int b, input int n);
        ok = 1'b0;
        for (int k = 0; k < n && !ok; k++) begin
            apb(1'b0, idx, 32'h0);
            ok = rd[b];
        end
    endtask
    task automatic wave(input logic r, input logic [15:0] h, input logic [23:0] a);
        @(posedge clk);
        run <= r;
        half <= h;
        amp <= a;
    endtask
    task automatic wait_zx(input int n);
        int k;
        repeat (n) begin
            for (k = 0; k < 1000 && cal_zx !== 1'b1; k++) @(posedge clk);
            if (k == 1000) hang("crossing pulse");
            @(posedge clk);
        end
    endtask
    task automatic t_regs();
        rdchk("timeout reload reset", `LPQM_IDX_CROSSING_TIMEOUT_RELOAD, 32'h00000FFF);
        rdchk("first_mode_control reset", `LPQM_IDX_FIRST_MODE_CONTROL, 32'h0);
        apb(1'b1, `LPQM_IDX_CROSSING_TIMEOUT_RELOAD, 32'h00000123);
        rdchk("timeout reload rw", `LPQM_IDX_CROSSING_TIMEOUT_RELOAD, 32'h00000123);
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped error", 32'h1, perr);
        chk("unmapped data", 32'h0, rd);
    endtask
    task automatic t_zx();
        apb(1'b1, `LPQM_IDX_MIRQST, 32'h0000000F);
        apb(1'b1, `LPQM_IDX_MIRQEN, 32'h00000001);
        wave(1'b1, 16'h0080, 24'h100000); // filter left on for a 50/60 Hz style line
        poll(`LPQM_IDX_MIRQST, 0, 300);
        chk("crossing flag", 32'h1, {31'h0, ok});
        chk("metering irq", 32'h1, {31'h0, mirq});
        wait_zx(1);
        chk("crossing output", 32'h1, {31'h0, zx});
        apb(1'b1, `LPQM_IDX_MIRQST, 32'h00000001);
        apb(1'b0, `LPQM_IDX_MIRQST, 32'h0);
        chk("crossing flag cleared", 32'h0, {31'h0, rd[0]});
        chk("metering irq cleared", 32'h0, {31'h0, mirq});
    endtask
    task automatic t_integ();
        @(negedge clk) cap = samples.i;
        @(negedge clk) chk("raw current", {8'h00, cap}, {8'h00, i_proc});
        chk("current valid", 32'h1, {31'h0, i_proc_v});
        apb(1'b1, `LPQM_IDX_FIRST_MODE_CONTROL, 32'h00000001);
        @(negedge clk) cap = samples.i;
        @(negedge clk) chk("integrated current", 32'h1, {31'h0, i_proc !== cap});
        apb(1'b1, `LPQM_IDX_FIRST_MODE_CONTROL, 32'h0);
    endtask
    task automatic t_period();
        // bypassed filter, so no settling time is needed
        apb(1'b1, `LPQM_IDX_SECOND_MODE_CONTROL, 32'h00000002);
        wait_zx(3);
        apb(1'b0, `LPQM_IDX_LINE_PERIOD_OR_FREQUENCY, 32'h0);
        chk_rng("period", 32'h0000007F, 32'h00000081, rd);
        apb(1'b1, `LPQM_IDX_SECOND_MODE_CONTROL, 32'h00000003);
        wait_zx(2);
        repeat (30) @(posedge clk);
        apb(1'b0, `LPQM_IDX_LINE_PERIOD_OR_FREQUENCY, 32'h0);
        chk_rng("frequency", 32'h00640000 / 32'h00000081, 32'h00640000 / 32'h0000007F, rd);
        apb(1'b1, `LPQM_IDX_SECOND_MODE_CONTROL, 32'h00000002);
    endtask
    task automatic t_peak();
        wave(1'b0, 16'h0004, 24'h000800);
        apb(1'b1, `LPQM_IDX_VOLTAGE_PEAK_THRESHOLD, 32'h00000010);
        apb(1'b1, `LPQM_IDX_CURRENT_PEAK_THRESHOLD, 32'h00000010);
        apb(1'b1, `LPQM_IDX_MIRQEN, 32'h0000000C);
        rdchk("voltage record alias", `LPQM_IDX_VOLTAGE_PEAK_RECORD_RC, 32'h00100000);
        rdchk("voltage record after clear", `LPQM_IDX_VOLTAGE_PEAK_RECORD, 32'h0);
        apb(1'b0, `LPQM_IDX_CURRENT_PEAK_RECORD_RC, 32'h0);
        apb(1'b1, `LPQM_IDX_MIRQST, 32'h0000000F);
        wave(1'b1, 16'h0004, 24'h000800);
        repeat (20) @(posedge clk);
        wave(1'b0, 16'h0004, 24'h000800);
        apb(1'b0, `LPQM_IDX_MIRQST, 32'h0);
        chk("peak flags below level", 32'h0, rd & 32'h0000000C);
        rdchk("voltage record", `LPQM_IDX_VOLTAGE_PEAK_RECORD, 32'h00000800);
        wave(1'b1, 16'h0004, 24'h123456);
        repeat (20) @(posedge clk);
        wave(1'b0, 16'h0004, 24'h123456);
        apb(1'b0, `LPQM_IDX_MIRQST, 32'h0);
        chk("peak flags above level", 32'h0000000C, rd & 32'h0000000C);
        chk("peak irq", 32'h1, {31'h0, mirq});
        rdchk("current record alias", `LPQM_IDX_CURRENT_PEAK_RECORD_RC, 32'h00123456);
    endtask
    task automatic t_sag();
        apb(1'b1, `LPQM_IDX_SAG_THRESHOLD, 32'h0000FFFF);
        apb(1'b1, `LPQM_IDX_SAG_CYCLE_COUNT, 32'h00000004);
        apb(1'b1, `LPQM_IDX_PSMEN, 32'h00000001);
        apb(1'b1, `LPQM_IDX_PSMFL, 32'h00000001);
        wave(1'b1, 16'h0080, 24'h000100);
        // third crossing closes the second full cycle below: one short of the count
        wait_zx(3);
        apb(1'b0, `LPQM_IDX_PSMFL, 32'h0);
        chk("sag flag early", 32'h0, {31'h0, rd[0]});
        wait_zx(1);
        apb(1'b0, `LPQM_IDX_PSMFL, 32'h0);
        chk("sag flag", 32'h1, {31'h0, rd[0]});
        chk("supply irq", 32'h1, {31'h0, pirq});
    endtask
    task automatic t_timeout();
        apb(1'b1, `LPQM_IDX_MIRQEN, 32'h00000002);
        apb(1'b1, `LPQM_IDX_CROSSING_TIMEOUT_RELOAD, 32'h00000100);
        wait_zx(1);
        apb(1'b1, `LPQM_IDX_MIRQST, 32'h0000000F);
        wave(1'b0, 16'h0080, 24'h000100);
        t0 = cyc;
        apb(1'b0, `LPQM_IDX_MIRQST, 32'h0);
        chk("timeout flag early", 32'h0, {31'h0, rd[1]});
        poll(`LPQM_IDX_MIRQST, 1, 400);
        chk_rng("timeout delay", 32'h000003DE, 32'h00000410, cyc - t0);
        chk("timeout irq", 32'h1, {31'h0, mirq});
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_zx();
        t_integ();
        t_period();
        t_peak();
        t_sag();
        t_timeout();
        wrap_up();
    end
endmodule // line_power_quality_monitor_bench
`default_nettype wire

// File: tb/lpqm_wave_src.sv
`default_nettype none
module lpqm_wave_src import lpqm_pkg::*; (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic [15:0] half_i,
    input wire logic [23:0] amp_i,
    output var lpqm_sample_t samples_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_q = 16'h0000;
    logic neg_q = 1'b1;
    logic [23:0] val;
    assign val = neg_q ? 24'h000000 - amp_i : amp_i;
    initial samples_o = '0;
    // square wave, one sample a cycle; both channels carry the same value
    always @(posedge clk_i) begin
        if (run_i) begin
            cnt_q <= (cnt_q + 16'h0001 >= half_i) ? 16'h0000 : cnt_q + 16'h0001;
            neg_q <= (cnt_q + 16'h0001 >= half_i) ? !neg_q : neg_q;
            samples_o <= '{1'b1, val, val};
        end else begin
            // stale data keeps moving so a missing valid is never masked by a lucky match
            samples_o <= '{1'b0, ~samples_o.v, ~samples_o.i};
        end
    end
endmodule // lpqm_wave_src
`default_nettype wire
